// ---- shared/enet_event_map.vh ----
// Register offsets, bit positions and timing constants of the event and control block
`ifndef ENET_EVENT_MAP_VH
`define ENET_EVENT_MAP_VH

// Byte offsets within the controller window
`define ADDR_EVENT 14'h3004
`define ADDR_ENABLE 14'h3008
`define ADDR_CONTROL 14'h3024
`define ADDR_MGMT_DATA 14'h3040
`define ADDR_MGMT_SPEED 14'h3044

// Event bit positions, word bit = 31 - printed bit
`define EV_HEARTBEAT 31
`define EV_RX_OVERSIZE 30
`define EV_TX_OVERSIZE 29
`define EV_GRACEFUL 28
`define EV_TX_FRAME 27
`define EV_MGMT_DONE 23
`define EV_LATE_COL 21
`define EV_RETRY_LIM 20
`define EV_TX_UNDERRUN 19
`define EV_TX_FIFO_FAULT 18
`define EV_RX_FIFO_FAULT 17
`define EV_IMPL_MASK 32'hf8be0000

// Control register fields
`define CTL_TAG_HI 31
`define CTL_TAG_LO 28
`define CTL_TEST_MODE 26
`define CTL_SPARE_OE 2
`define CTL_GLOBAL_EN 1
`define CTL_LOCAL_RESET 0
`define TAG_RESET 4'hf

// Speed register field, printed bits 25:30
`define SPEED_HI 6
`define SPEED_LO 1
`define SPEED_PREAMBLE_OFF 7

// Local reset sequence length in clocks
`define LOCAL_RESET_CYCLES 4'h8
// Retry limit for half duplex collisions
`define RETRY_LIMIT 5'h10

`endif

// ---- logic/enet_event_mask_control.v ----
// Event flags, interrupt enables, global control and management frame launch
// Notes on behaviour
// - Heartbeat flag sets when checking is on and no collision follows a send.
// - Receive oversize flag sets when a received frame exceeds max length.
// - Transmit oversize flag sets on a long frame; frame still sent whole.
// - Graceful stop flag sets when transmitter pauses after the current frame.
// - Transmit frame flag sets for each frame sent.
// - Management done flag sets when the PHY transfer completes.
// - Half duplex late collision sets flag, ends frame with bad CRC.
// - Half duplex sixteen collided attempts set retry flag, frame dropped.
// - FIFO underrun sets flag, bad CRC appended, remainder dropped.
// - Transmit or receive FIFO fault clears the global enable.
// - Interrupt is high while any event and its enable are both set.
// - Enable register is read/write and cleared by hardware reset.
// - Global enable gates receive and transmit at once; clearing it strobes bad CRC.
// - Writing one to local reset clears the global enable.
// - Local reset restores all registers but management and read data, aborts transfers, self clears in 8.
// - Test tag resets to all ones, drives tag bus, read value latched.
// - Test mode bit makes bus controller accept only slave interface requests.
// - Spare output enable bit is plain storage.
// - Management data write launches a frame unless divider is zero.
// - Divider written non-zero later launches the pending stored frame.
// - Management data register has no defined reset value.
// - Event bits clear on write of one; hardware reset clears all.
// - Divider N gives management clock of bus clock over 2N; zero holds low.
//
// Strobed register access was decided locally.
`include "enet_event_map.vh"
`timescale 1ns/1ns
`default_nettype none

module enet_event_mask_control #(
  parameter ADDR_WIDTH = 14
) (
  input wire clk,
  input wire sys_rst,
  input wire [ADDR_WIDTH-1:0] regAddr,
  input wire [31:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regReadData,
  output wire irq,
  // Transmit/receive engine status, same clock domain
  input wire halfDuplex,
  input wire heartbeatCheckEnable,
  input wire heartbeatMissed,
  input wire rxOversize,
  input wire txOversize,
  input wire txPaused,
  input wire txFrameDone,
  input wire txCollision,
  input wire txPastSlotTime,
  input wire txAttemptStart,
  input wire txUnderrun,
  input wire txFifoFault,
  input wire rxFifoFault,
  input wire mgmtDone,
  // Controls toward the engines
  output wire rxEnable,
  output wire txEnable,
  output reg txBadCrc,
  output reg txDiscard,
  output reg txRetryLimit,
  output wire localResetActive,
  output wire testSlaveOnly,
  output wire spareOutputEnable,
  output reg [3:0] tagBusOut,
  output wire tagBusDrive,
  input wire [3:0] tagBusIn,
  output reg mgmtStart,
  output reg [31:0] mgmtFrame,
  output wire preambleOff,
  output reg mgmtClock
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  function hit;
    input [ADDR_WIDTH-1:0] a;
    input [13:0] target;
    begin
      hit = (a == target[ADDR_WIDTH-1:0]);
    end
  endfunction

  wire wrEvent = regWrite && hit(regAddr, `ADDR_EVENT);
  wire wrEnable = regWrite && hit(regAddr, `ADDR_ENABLE);
  wire wrControl = regWrite && hit(regAddr, `ADDR_CONTROL);
  wire wrData = regWrite && hit(regAddr, `ADDR_MGMT_DATA);
  wire wrSpeed = regWrite && hit(regAddr, `ADDR_MGMT_SPEED);

  reg [31:0] interruptEvent;
  reg [31:0] interruptEnable;
  reg globalEnable;
  reg testMode;
  reg spareOe;
  reg [3:0] tagIn;
  reg [3:0] tagOut;
  reg [3:0] resetCount;
  reg [5:0] speed;
  reg skipPreamble;
  reg mgmtPending;
  reg [5:0] divCount;
  reg [4:0] attempts;

  // Local reset holds every register except management data and read data at its reset value for 8 cycles
  wire localReset = (resetCount != 4'h0);
  wire anyReset = sys_rst || localReset;
  assign localResetActive = localReset;

  // ------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------
  // Retry counting lives here since the limit sets a flag
  wire collideEarly = halfDuplex && txCollision && !txPastSlotTime;
  wire retryHit = collideEarly && (attempts == `RETRY_LIMIT - 5'h1);
  wire lateCol = halfDuplex && txCollision && txPastSlotTime;

  reg [31:0] eventSet;
  always @* begin
    eventSet = 32'h0;
    eventSet[`EV_HEARTBEAT] = heartbeatCheckEnable && heartbeatMissed;
    eventSet[`EV_RX_OVERSIZE] = rxOversize;
    eventSet[`EV_TX_OVERSIZE] = txOversize;
    eventSet[`EV_GRACEFUL] = txPaused;
    eventSet[`EV_TX_FRAME] = txFrameDone;
    eventSet[`EV_MGMT_DONE] = mgmtDone;
    eventSet[`EV_LATE_COL] = lateCol;
    eventSet[`EV_RETRY_LIM] = retryHit;
    eventSet[`EV_TX_UNDERRUN] = txUnderrun;
    eventSet[`EV_TX_FIFO_FAULT] = txFifoFault;
    eventSet[`EV_RX_FIFO_FAULT] = rxFifoFault;
  end

  // ------------------------------------------------------------
  // Event and enable registers
  // ------------------------------------------------------------
  // New events win over a same-cycle clear
  always @(posedge clk) begin
    if (anyReset) begin
      interruptEvent <= 32'h0;
      interruptEnable <= 32'h0;
    end else begin
      interruptEvent <= ((interruptEvent & ~(wrEvent ? regWriteData : 32'h0)) | eventSet)
        & `EV_IMPL_MASK;
      if (wrEnable) begin
        interruptEnable <= regWriteData & `EV_IMPL_MASK;
      end
    end
  end

  assign irq = |(interruptEvent & interruptEnable);

  always @(posedge clk) begin
    if (anyReset) begin
      attempts <= 5'h0;
    end else if (txFrameDone || retryHit || lateCol) begin
      attempts <= 5'h0;
    end else if (collideEarly) begin
      attempts <= attempts + 5'h1;
    end
  end

  // Any cause other than reset that drops the global enable on this edge
  wire writeReset = wrControl && regWriteData[`CTL_LOCAL_RESET];
  wire fifoFault = txFifoFault || rxFifoFault;
  wire next_disable = writeReset || fifoFault ||
    (wrControl && !regWriteData[`CTL_GLOBAL_EN]);

  // Transmit frame termination strobes toward the engine
  always @(posedge clk) begin
    if (anyReset) begin
      txBadCrc <= 1'b0;
      txDiscard <= 1'b0;
      txRetryLimit <= 1'b0;
    end else begin
      txBadCrc <= lateCol || txUnderrun || (globalEnable && next_disable);
      txDiscard <= lateCol || txUnderrun || retryHit;
      txRetryLimit <= retryHit;
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      resetCount <= 4'h0;
    end else if (writeReset && !localReset) begin
      resetCount <= `LOCAL_RESET_CYCLES;
    end else if (localReset) begin
      resetCount <= resetCount - 4'h1;
    end
  end

  always @(posedge clk) begin
    if (anyReset) begin
      globalEnable <= 1'b0;
      testMode <= 1'b0;
      spareOe <= 1'b0;
      tagIn <= `TAG_RESET;
    end else begin
      if (writeReset || fifoFault) begin
        globalEnable <= 1'b0;
      end else if (wrControl) begin
        globalEnable <= regWriteData[`CTL_GLOBAL_EN];
      end
      if (wrControl) begin
        testMode <= regWriteData[`CTL_TEST_MODE];
        spareOe <= regWriteData[`CTL_SPARE_OE];
        tagIn <= regWriteData[`CTL_TAG_HI:`CTL_TAG_LO];
      end
    end
  end

  assign rxEnable = globalEnable;
  assign txEnable = globalEnable;
  assign testSlaveOnly = testMode;
  assign spareOutputEnable = spareOe;

  // Tag bus: driven on writes elsewhere, sampled on reads
  assign tagBusDrive = regWrite && !hit(regAddr, `ADDR_CONTROL);
  always @(posedge clk) begin
    if (anyReset) begin
      tagOut <= `TAG_RESET;
      tagBusOut <= `TAG_RESET;
    end else begin
      tagBusOut <= tagIn;
      if (regRead) begin
        tagOut <= tagBusIn;
      end
    end
  end

  // ------------------------------------------------------------
  // Management launch and clock
  // ------------------------------------------------------------
  // Data keeps no reset so software sees whatever was left behind
  always @(posedge clk) begin
    if (wrData) begin
      mgmtFrame <= regWriteData;
    end
  end

  wire [5:0] next_speed = regWriteData[`SPEED_HI:`SPEED_LO];

  always @(posedge clk) begin
    if (anyReset) begin
      speed <= 6'h0;
      skipPreamble <= 1'b0;
      mgmtPending <= 1'b0;
      mgmtStart <= 1'b0;
    end else begin
      mgmtStart <= 1'b0;
      if (wrSpeed) begin
        speed <= next_speed;
        skipPreamble <= regWriteData[`SPEED_PREAMBLE_OFF];
      end
      if (wrData && speed == 6'h0 && !(wrSpeed && next_speed != 6'h0)) begin
        mgmtPending <= 1'b1;
      end else if (wrData) begin
        mgmtStart <= 1'b1;
        mgmtPending <= 1'b0;
      end else if (mgmtPending && wrSpeed && next_speed != 6'h0) begin
        mgmtStart <= 1'b1;
        mgmtPending <= 1'b0;
      end
    end
  end

  assign preambleOff = skipPreamble;

  // Toggle every N cycles gives bus clock over 2N
  always @(posedge clk) begin
    if (anyReset || speed == 6'h0) begin
      divCount <= 6'h0;
      mgmtClock <= 1'b0;
    end else if (divCount + 6'h1 >= speed) begin
      divCount <= 6'h0;
      mgmtClock <= ~mgmtClock;
    end else begin
      divCount <= divCount + 6'h1;
    end
  end

  // ------------------------------------------------------------
  // Read back
  // ------------------------------------------------------------
  reg [31:0] next_readData;
  always @* begin
    next_readData = 32'h0;
    if (hit(regAddr, `ADDR_EVENT)) begin
      next_readData = interruptEvent;
    end else if (hit(regAddr, `ADDR_ENABLE)) begin
      next_readData = interruptEnable;
    end else if (hit(regAddr, `ADDR_CONTROL)) begin
      next_readData[`CTL_TAG_HI:`CTL_TAG_LO] = tagOut;
      next_readData[`CTL_SPARE_OE] = spareOe;
      next_readData[`CTL_GLOBAL_EN] = globalEnable;
      next_readData[`CTL_LOCAL_RESET] = localReset;
    end else if (hit(regAddr, `ADDR_MGMT_DATA)) begin
      next_readData = mgmtFrame;
    end else if (hit(regAddr, `ADDR_MGMT_SPEED)) begin
      next_readData[`SPEED_PREAMBLE_OFF] = skipPreamble;
      next_readData[`SPEED_HI:`SPEED_LO] = speed;
    end
  end

  // layout is baked into the field constants
  always @(posedge clk) begin
    if (sys_rst) begin
      regReadData <= 32'h0;
    end else if (regRead) begin
      regReadData <= next_readData;
    end else begin
      regReadData <= 32'h0;
    end
  end

endmodule

`default_nettype wire

// ---- verification/enet_event_monitor.sv ----
// Port-level assertions for the event, enable and control block
`timescale 1ns/1ns
`default_nettype none
module enet_event_monitor (
  input wire clk,
  input wire sys_rst,
  input wire [13:0] regAddr,
  input wire [31:0] regWriteData,
  input wire regWrite,
  input wire irq,
  input wire txFifoFault,
  input wire rxFifoFault,
  input wire rxEnable,
  input wire txEnable,
  input wire halfDuplex,
  input wire txCollision,
  input wire txPastSlotTime,
  input wire txUnderrun,
  input wire txBadCrc,
  input wire txDiscard,
  input wire localResetActive,
  input wire [3:0] tagBusOut,
  input wire tagBusDrive,
  input wire mgmtStart,
  input wire [31:0] mgmtFrame
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire ctlWr = regWrite && regAddr == 14'h3024;
  // ------------------------------------------
  // Assertions
  // ------------------------------------------
  AST_RESET_STATE: assert property ($fell(sys_rst) |-> !irq && !txEnable && tagBusOut == 4'hf)
    else $error("outputs not at reset values");
  AST_FIFO_HALT: assert property ((txFifoFault || rxFifoFault) |-> ##[1:2] !txEnable)
    else $error("fifo fault left enable set");
  AST_EN_PAIR: assert property (rxEnable == txEnable)
    else $error("receive and transmit enables differ");
  AST_LRST_CLEAR: assert property (ctlWr && regWriteData[0] && !localResetActive |=> !txEnable && localResetActive)
    else $error("local reset did not clear enable");
  AST_LRST_LEN: assert property ($rose(localResetActive) |-> localResetActive[*6] ##[1:4] !localResetActive)
    else $error("local reset length wrong");
  AST_LATE_COL: assert property (halfDuplex && txCollision && txPastSlotTime |=> txBadCrc && txDiscard)
    else $error("late collision not truncated");
  AST_UNDERRUN: assert property (txUnderrun |=> txBadCrc && txDiscard)
    else $error("underrun not truncated");
  AST_TAG_BUS: assert property (tagBusDrive == (regWrite && regAddr != 14'h3024))
    else $error("tag bus drive wrong");
  AST_MGMT_STORE: assert property (regWrite && regAddr == 14'h3040 && !localResetActive |=> mgmtFrame == $past(regWriteData))
    else $error("management data not stored");
  AST_MGMT_CAUSE: assert property (mgmtStart |-> $past(regWrite))
    else $error("frame launched without a write");
  cover property (mgmtStart);
  cover property ($rose(localResetActive));
  cover property ($rose(irq));
endmodule
bind enet_event_mask_control enet_event_monitor mon (.clk(clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .irq(irq),
  .txFifoFault(txFifoFault), .rxFifoFault(rxFifoFault), .rxEnable(rxEnable),
  .txEnable(txEnable), .halfDuplex(halfDuplex), .txCollision(txCollision),
  .txPastSlotTime(txPastSlotTime), .txUnderrun(txUnderrun), .txBadCrc(txBadCrc),
  .txDiscard(txDiscard), .localResetActive(localResetActive), .tagBusOut(tagBusOut),
  .tagBusDrive(tagBusDrive), .mgmtStart(mgmtStart), .mgmtFrame(mgmtFrame));
`default_nettype wire

// ---- verification/enet_engine_model.sv ----
// Engine stand-in raising one status pulse per command, after a delay
`timescale 1ns/1ns
`default_nettype none
module enet_engine_model (
  input wire clk,
  input wire fire,
  input wire [3:0] sel,
  input wire [3:0] holdOff,
  output logic [9:0] pulse,
  output logic [3:0] tagBusIn
);
  logic [3:0] left = 4'h0;
  logic [3:0] pend = 4'h0;
  logic busy = 1'b0;
  initial pulse = 10'h0;
  initial tagBusIn = 4'h9;
  always @(posedge clk) begin
    pulse <= 10'h0;
    // Undriven tag bus: the update maps 9 back to 9, so it holds its initial 9
    tagBusIn <= ~tagBusIn + 4'h3;
    if (fire) begin
      busy <= 1'b1;
      left <= holdOff;
      pend <= sel;
    end else if (busy && left != 4'h0) begin
      left <= left - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      pulse <= 10'h1 << pend;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the event, enable and control block
`timescale 1ns/1ns
`default_nettype none
`include "enet_event_map.vh"
module tb;
  logic clk = 1'b0, sysRst = 1'b1, regWrite = 1'b0, regRead = 1'b0, fire = 1'b0;
  logic halfDup = 1'b1, pastSlot = 1'b1, rdSeen = 1'b0, mdcPrev = 1'b0, hbCheck = 1'b1;
  logic [63:0] note;
  logic [13:0] regAddr = 14'h0;
  logic [31:0] regWriteData = 32'h0, seed = 32'h00002ed3, r, b, d, nStart = 0, nRise = 0;
  logic [3:0] sel = 4'h0, holdOff = 4'h0, tagIn, tagBusOut;
  logic [9:0] pulse;
  logic [31:0] regReadData, mgmtFrame;
  logic irq, txEnable, localResetActive, testSlaveOnly, spareOutputEnable, mgmtStart, mgmtClock;
  logic [63:0] notes[$];
  logic [4:0] bitOf[10] = '{5'h1f, 5'h1e, 5'h1d, 5'h1c, 5'h1b, 5'h15, 5'h13, 5'h12, 5'h11, 5'h17};
  int checks = 0, nMismatch = 0, k;
  always #10 clk = ~clk;
  enet_engine_model eng (.clk(clk), .fire(fire), .sel(sel), .holdOff(holdOff),
    .pulse(pulse), .tagBusIn(tagIn));
  enet_event_mask_control uut (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .irq(irq), .halfDuplex(halfDup), .heartbeatCheckEnable(hbCheck),
    .heartbeatMissed(pulse[0]), .rxOversize(pulse[1]), .txOversize(pulse[2]),
    .txPaused(pulse[3]), .txFrameDone(pulse[4]), .txCollision(pulse[5]),
    .txPastSlotTime(pastSlot), .txAttemptStart(1'b0), .txUnderrun(pulse[6]),
    .txFifoFault(pulse[7]), .rxFifoFault(pulse[8]), .mgmtDone(pulse[9]), .rxEnable(),
    .txEnable(txEnable), .txBadCrc(), .txDiscard(), .txRetryLimit(),
    .localResetActive(localResetActive), .testSlaveOnly(testSlaveOnly),
    .spareOutputEnable(spareOutputEnable), .tagBusOut(tagBusOut), .tagBusDrive(),
    .tagBusIn(tagIn), .mgmtStart(mgmtStart), .mgmtFrame(mgmtFrame), .preambleOff(),
    .mgmtClock(mgmtClock));
  // ------------------------------------------
  // Tasks and read-result watcher
  // ------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // Mask hides fields whose read value is not predictable here
  task automatic rd(input logic [13:0] a, input logic [31:0] m, input logic [31:0] e);
    notes.push_back({m, e & m});
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
  endtask
  task automatic kick(input logic [3:0] s);
    r = rnd();
    @(posedge clk);
    sel <= s;
    holdOff <= {2'h0, r[1:0]};
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    rdSeen <= regRead;
    mdcPrev <= mgmtClock;
    nStart <= nStart + {31'h0, mgmtStart};
    nRise <= nRise + {31'h0, mgmtClock & ~mdcPrev};
  end
  always @(negedge clk) begin
    if (rdSeen && notes.size() != 0) begin
      note = notes.pop_front();
      chk(regReadData & note[63:32], note[31:0]);
    end
  end
  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    rd(`ADDR_ENABLE, 32'hffffffff, 32'h0);
    rd(`ADDR_EVENT, 32'hffffffff, 32'h0);
    rd(14'h3010, 32'hffffffff, 32'h0);
    r = rnd();
    wr(`ADDR_ENABLE, r);
    rd(`ADDR_ENABLE, 32'hffffffff, r & `EV_IMPL_MASK);
    wr(`ADDR_ENABLE, 32'hffffffff);
    // Missed heartbeat with checking off must not flag
    hbCheck <= 1'b0;
    kick(4'h0);
    rd(`ADDR_EVENT, 32'hffffffff, 32'h0);
    hbCheck <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      wr(`ADDR_CONTROL, 32'ha0000002);
      kick(i[3:0]);
      b = 32'h1 << bitOf[i];
      rd(`ADDR_EVENT, 32'hffffffff, b);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, txEnable}, {31'h0, i < 7 || i > 8});
      wr(`ADDR_EVENT, ~b);
      rd(`ADDR_EVENT, b, b);
      wr(`ADDR_EVENT, b);
      rd(`ADDR_EVENT, 32'hffffffff, 32'h0);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    kick(4'h4);
    wr(`ADDR_ENABLE, 32'h0);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    pastSlot <= 1'b0;
    for (int i = 1; i <= 16; i++) begin
      kick(4'h5);
      if (i == 15) rd(`ADDR_EVENT, 32'h00100000, 32'h0);
    end
    rd(`ADDR_EVENT, 32'h00100000, 32'h00100000);
    wr(`ADDR_CONTROL, 32'h2c000006);
    // Tag bus copy lags the stored tag by one clock
    @(posedge clk);
    @(negedge clk);
    chk({28'h0, tagBusOut}, 32'h2);
    chk({30'h0, testSlaveOnly, spareOutputEnable}, 32'h3);
    rd(`ADDR_CONTROL, 32'h00000006, 32'h6);
    r = rnd();
    d = {4'h5, r[27:18], 2'h2, r[15:0]};
    b = nStart;
    wr(`ADDR_MGMT_DATA, d);
    repeat (4) @(posedge clk);
    chk(nStart - b, 32'h0);
    chk({31'h0, mgmtClock}, 32'h0);
    wr(`ADDR_MGMT_SPEED, 32'h4);
    repeat (4) @(posedge clk);
    chk(nStart - b, 32'h1);
    chk(mgmtFrame, d);
    r = nRise;
    repeat (40) @(posedge clk);
    chk(nRise - r, 32'ha);
    wr(`ADDR_MGMT_DATA, d ^ 32'hffff);
    repeat (4) @(posedge clk);
    chk(nStart - b, 32'h2);
    wr(`ADDR_ENABLE, 32'hffffffff);
    wr(`ADDR_CONTROL, 32'h00000003);
    @(negedge clk);
    chk({31'h0, txEnable}, 32'h0);
    k = 0;
    while (localResetActive !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(k < 20, 32'h1);
    rd(`ADDR_ENABLE, 32'hffffffff, 32'h0);
    rd(`ADDR_EVENT, 32'hffffffff, 32'h0);
    repeat (3) @(posedge clk);
    chk({28'h0, tagBusOut}, 32'hf);
    conclude();
  end
endmodule
`default_nettype wire
